// ### tcc_pkg.sv
`default_nettype none
package tcc_pkg;
    // ==========================================================
    // Widths
    localparam int COUNT_W = 16;
    localparam int DATA_W  = 32;
    localparam int ADR_W   = 8;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_SNAPSHOT  = 8'h00;
    localparam logic [7:0] OFS_COMPARE_A = 8'h04;
    localparam logic [7:0] OFS_COMPARE_B = 8'h08;
    localparam logic [7:0] OFS_CAPTURE_A = 8'h0C;
    localparam logic [7:0] OFS_CAPTURE_B = 8'h10;
    localparam logic [7:0] OFS_CONTROL   = 8'h14;
    localparam logic [7:0] OFS_STATUS    = 8'h18;

    // ==========================================================
    // Field positions
    localparam int CTRL_TOGGLE_EN_BIT = 0;
    localparam int STAT_MATCH_A_BIT   = 0;
    localparam int STAT_MATCH_B_BIT   = 1;

    // ==========================================================
    // Reset values
    localparam logic [15:0] COMPARE_RST = 16'h0000;
    localparam logic [15:0] UPPER_ZERO  = 16'h0000;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;
endpackage
`default_nettype wire

// ### tcc_regs.sv
// Contract
// - Snapshot read returns live counter, upper zero
// - Compare A: 16-bit RW, reset zero
// - Compare B: independent 16-bit RW, reset zero
// - Capture A latches counter, read-only, no reset
// - Capture B latches counter, read-only, no reset
// - Counter equals compare A sets match flag
// - Capture A load toggles output when enabled
`timescale 1ns/100ps
`default_nettype none
module tcc_regs
(
    input  wire logic                           clk_i,
    input  wire logic                           sys_rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [tcc_pkg::ADR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [tcc_pkg::DATA_W-1:0]     wb_dat_i,
    output logic      [tcc_pkg::DATA_W-1:0]     wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic [tcc_pkg::COUNT_W-1:0]    count_i,
    input  wire logic                           capture_a_i,
    input  wire logic                           capture_b_i,
    output logic      [tcc_pkg::COUNT_W-1:0]    compare_value_a_o,
    output logic      [tcc_pkg::COUNT_W-1:0]    compare_value_b_o,
    output logic                                match_flag_a_o,
    output logic                                match_flag_b_o,
    output logic                                timer_output_flipflop_o
);
    import tcc_pkg::*;

    // ==========================================================
    // Helpers
    // Upper lanes dropped: the compare registers are 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        merge16 = old_v;
        if (sel[0])
        begin
            merge16[7:0] = wdat[7:0];
        end
        if (sel[1])
        begin
            merge16[15:8] = wdat[15:8];
        end
    endfunction

    function automatic logic [31:0] zext16(input logic [15:0] v);
        zext16 = {UPPER_ZERO, v};
    endfunction

    // ==========================================================
    // Bus decode
    logic                 req;
    logic                 commit;
    logic                 ack_r;
    logic                 ack_nxt;
    logic [DATA_W-1:0]    dat_r;
    logic [DATA_W-1:0]    dat_nxt;
    logic [COUNT_W-1:0]   cmp_a_r;
    logic [COUNT_W-1:0]   cmp_a_nxt;
    logic [COUNT_W-1:0]   cmp_b_r;
    logic [COUNT_W-1:0]   cmp_b_nxt;
    logic                 tog_en_r;
    logic                 tog_en_nxt;
    logic                 flag_a_r;
    logic                 flag_a_nxt;
    logic                 flag_b_r;
    logic                 flag_b_nxt;
    logic                 tff_r;
    logic                 tff_nxt;
    logic [COUNT_W-1:0]   cap_a_r;
    logic [COUNT_W-1:0]   cap_a_nxt;
    logic [COUNT_W-1:0]   cap_b_r;
    logic [COUNT_W-1:0]   cap_b_nxt;

    // Request taken on first cycle; write and read clear commit on ack edge
    assign req    = wb_cyc_i && wb_stb_i && !ack_r;
    assign commit = wb_cyc_i && wb_stb_i && ack_r;

    // ==========================================================
    // Bus answer and read mux
    always_comb
    begin
        ack_nxt = req;
        dat_nxt = dat_r;
        // Snapshot is the count at the request edge, not the ack edge
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                OFS_SNAPSHOT:  dat_nxt = zext16(count_i);
                OFS_COMPARE_A: dat_nxt = zext16(cmp_a_r);
                OFS_COMPARE_B: dat_nxt = zext16(cmp_b_r);
                OFS_CAPTURE_A: dat_nxt = zext16(cap_a_r);
                OFS_CAPTURE_B: dat_nxt = zext16(cap_b_r);
                OFS_CONTROL:   dat_nxt = {31'h0000_0000, tog_en_r};
                OFS_STATUS:    dat_nxt = {30'h0000_0000, flag_b_r, flag_a_r};
                default:       dat_nxt = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= DATA_ZERO;
        end
        else
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    // ==========================================================
    // Software-written state
    always_comb
    begin
        cmp_a_nxt  = cmp_a_r;
        cmp_b_nxt  = cmp_b_r;
        tog_en_nxt = tog_en_r;
        if (commit && wb_we_i)
        begin
            case (wb_adr_i)
                OFS_COMPARE_A: cmp_a_nxt = merge16(cmp_a_r, wb_dat_i, wb_sel_i);
                OFS_COMPARE_B: cmp_b_nxt = merge16(cmp_b_r, wb_dat_i, wb_sel_i);
                OFS_CONTROL:
                begin
                    if (wb_sel_i[0])
                    begin
                        tog_en_nxt = wb_dat_i[CTRL_TOGGLE_EN_BIT];
                    end
                end
                default:
                begin
                    cmp_a_nxt = cmp_a_r;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cmp_a_r  <= COMPARE_RST;
            cmp_b_r  <= COMPARE_RST;
            tog_en_r <= 1'b0;
        end
        else
        begin
            cmp_a_r  <= cmp_a_nxt;
            cmp_b_r  <= cmp_b_nxt;
            tog_en_r <= tog_en_nxt;
        end
    end

    // ==========================================================
    // Match flags and output flip-flop
    // Set beats the read-clear so a match in the clearing cycle survives
    always_comb
    begin
        logic clr;
        clr = commit && !wb_we_i && (wb_adr_i == OFS_STATUS);
        flag_a_nxt = (count_i == cmp_a_r) || (flag_a_r && !clr);
        flag_b_nxt = (count_i == cmp_b_r) || (flag_b_r && !clr);
        tff_nxt    = tff_r ^ (capture_a_i && tog_en_r);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
            tff_r    <= 1'b0;
        end
        else
        begin
            flag_a_r <= flag_a_nxt;
            flag_b_r <= flag_b_nxt;
            tff_r    <= tff_nxt;
        end
    end

    // ==========================================================
    // Capture storage
    // No reset: contents are undefined until the first capture
    always_comb
    begin
        cap_a_nxt = capture_a_i ? count_i : cap_a_r;
        cap_b_nxt = capture_b_i ? count_i : cap_b_r;
    end

    always_ff @(posedge clk_i)
    begin
        cap_a_r <= cap_a_nxt;
        cap_b_r <= cap_b_nxt;
    end

    // ==========================================================
    // Outputs
    assign wb_ack_o                = ack_r;
    assign wb_dat_o                = dat_r;
    assign compare_value_a_o       = cmp_a_r;
    assign compare_value_b_o       = cmp_b_r;
    assign match_flag_a_o          = flag_a_r;
    assign match_flag_b_o          = flag_b_r;
    assign timer_output_flipflop_o = tff_r;

    // ==========================================================
    // Checks
    sequence rd_taken(logic [7:0] ofs);
        req && !wb_we_i && wb_adr_i == ofs;
    endsequence

    sequence wr_full(logic [7:0] ofs);
        commit && wb_we_i && wb_adr_i == ofs && wb_sel_i[1:0] == 2'b11;
    endsequence

    sequence cap_then_read(logic cap, logic [7:0] ofs);
        cap ##1 rd_taken(ofs);
    endsequence

    snapshot_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_taken(OFS_SNAPSHOT) |=> wb_ack_o && wb_dat_o == {16'h0000, $past(count_i)})
        else $error("snapshot read wrong");

    compare_a_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_full(OFS_COMPARE_A) |=> compare_value_a_o == $past(wb_dat_i[15:0]))
        else $error("compare a write lost");

    compare_a_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rd_taken(OFS_COMPARE_A) |=> wb_dat_o == {16'h0000, $past(cmp_a_r)})
        else $error("compare a read wrong");

    compare_b_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_full(OFS_COMPARE_B) |=> compare_value_b_o == $past(wb_dat_i[15:0])
            && $stable(compare_value_a_o))
        else $error("compare b write wrong");

    capture_a_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cap_then_read(capture_a_i, OFS_CAPTURE_A)
            |=> wb_dat_o == {16'h0000, $past(count_i, 2)})
        else $error("capture a value wrong");

    capture_b_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cap_then_read(capture_b_i, OFS_CAPTURE_B)
            |=> wb_dat_o == {16'h0000, $past(count_i, 2)})
        else $error("capture b read wrong");

    capture_keep_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !capture_a_i |=> $stable(cap_a_r))
        else $error("capture a changed without event");

    capture_b_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture_b_i |=> cap_b_r == $past(count_i))
        else $error("capture b value wrong");

    match_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        count_i == compare_value_a_o |=> match_flag_a_o)
        else $error("match flag a not set");

    toggle_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        capture_a_i && tog_en_r |=> timer_output_flipflop_o != $past(timer_output_flipflop_o))
        else $error("output flip-flop not inverted");

    hold_out_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(capture_a_i && tog_en_r) |=> $stable(timer_output_flipflop_o))
        else $error("output flip-flop moved");

    read_clean_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        commit && !wb_we_i && !capture_a_i && !capture_b_i
            |=> $stable(cmp_a_r) && $stable(cmp_b_r) && $stable(cap_a_r) && $stable(cap_b_r))
        else $error("read disturbed state");

    ack_shape_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");

    upper_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wb_ack_o |-> wb_dat_o[31:16] == UPPER_ZERO)
        else $error("upper read bits not zero");

    // Clear only sticks once count and compare differ
    flag_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        commit && !wb_we_i && wb_adr_i == OFS_STATUS && count_i != cmp_a_r |=> !match_flag_a_o)
        else $error("match flag a not cleared");

    compare_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(commit && wb_we_i) |=> $stable(compare_value_a_o) && $stable(compare_value_b_o))
        else $error("compare changed without write");

    reset_values_a: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> compare_value_a_o == COMPARE_RST
            && compare_value_b_o == COMPARE_RST && !match_flag_a_o
            && !timer_output_flipflop_o && !wb_ack_o)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// ### timer_compare_capture_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer_compare_capture_regs_tb;
    import tcc_pkg::*;
    typedef struct packed {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] wd;
        logic [31:0] exp;
    } tcc_row_t;

    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        wb_cyc_i  = 1'b0;
    logic        wb_stb_i  = 1'b0;
    logic        wb_we_i   = 1'b0;
    logic [7:0]  wb_adr_i  = 8'h00;
    logic [3:0]  wb_sel_i  = 4'h0;
    logic [31:0] wb_dat_i  = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [15:0] count_i   = 16'h1234;
    // Captures load during reset so stored values start known
    logic        cap_a     = 1'b1;
    logic        cap_b     = 1'b1;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic        flag_a;
    logic        flag_b;
    logic        tff;
    logic [31:0] rd;
    int          mismatches  = 0;
    int          check_count = 0;
    tcc_row_t    rows [9] = '{
        '{1'b0, OFS_COMPARE_A, 32'h0, 32'h0000_0000},
        '{1'b0, OFS_COMPARE_B, 32'h0, 32'h0000_0000},
        '{1'b1, OFS_COMPARE_A, 32'hFFFF_ABCD, 32'h0},
        '{1'b1, OFS_COMPARE_B, 32'h1234_5678, 32'h0},
        '{1'b0, OFS_COMPARE_A, 32'h0, 32'h0000_ABCD},
        '{1'b0, OFS_COMPARE_B, 32'h0, 32'h0000_5678},
        '{1'b1, OFS_SNAPSHOT, 32'hFFFF_FFFF, 32'h0},
        '{1'b0, OFS_SNAPSHOT, 32'h0, 32'h0000_1234},
        '{1'b0, 8'h40, 32'h0, 32'h0000_0000}};

    always #10 clk_i = ~clk_i;

    tcc_regs dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_i(count_i),
        .capture_a_i(cap_a), .capture_b_i(cap_b), .compare_value_a_o(cmp_a),
        .compare_value_b_o(cmp_b), .match_flag_a_o(flag_a), .match_flag_b_o(flag_b),
        .timer_output_flipflop_o(tff));

    // ==========================================================
    // Checking and closing
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Bus cycle; called right after a rising edge, waits for ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    // Capture strobe held for exactly one sampling edge
    task automatic pulse(input logic b);
        if (b)
            cap_b <= 1'b1;
        else
            cap_a <= 1'b1;
        @(posedge clk_i);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
        @(posedge clk_i);
    endtask

    initial
    begin
        #200000;
        mismatches++;
        test_done();
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        cap_a     <= 1'b0;
        cap_b     <= 1'b0;
        @(posedge clk_i);
        chk("cmp_a_rst", {16'h0, cmp_a}, 32'h0);
        chk("cmp_b_rst", {16'h0, cmp_b}, 32'h0);
        $display("test reset done");
        foreach (rows[i])
        begin
            wb(rows[i].we, rows[i].adr, rows[i].wd);
            if (!rows[i].we) chk("row_read", rd, rows[i].exp);
        end
        chk("cmp_a_out", {16'h0, cmp_a}, 32'h0000_ABCD);
        chk("cmp_b_out", {16'h0, cmp_b}, 32'h0000_5678);
        $display("test table done");
        count_i <= 16'hBEEF;
        pulse(1'b0);
        count_i <= 16'hCAFE;
        pulse(1'b1);
        count_i <= 16'h0777;
        wb(1'b1, OFS_CAPTURE_A, 32'h0000_1111);
        wb(1'b0, OFS_CAPTURE_A, 32'h0);
        chk("cap_a", rd, 32'h0000_BEEF);
        wb(1'b0, OFS_CAPTURE_B, 32'h0);
        chk("cap_b", rd, 32'h0000_CAFE);
        // Reads must leave stored values alone
        wb(1'b0, OFS_SNAPSHOT, 32'h0);
        chk("snap_live", rd, 32'h0000_0777);
        wb(1'b0, OFS_CAPTURE_A, 32'h0);
        chk("cap_a_again", rd, 32'h0000_BEEF);
        chk("cmp_a_kept", {16'h0, cmp_a}, 32'h0000_ABCD);
        // Capture one edge before the read is taken
        count_i <= 16'h2468;
        cap_a   <= 1'b1;
        @(posedge clk_i);
        cap_a   <= 1'b0;
        count_i <= 16'h1357;
        wb(1'b0, OFS_CAPTURE_A, 32'h0);
        chk("cap_a_near", rd, 32'h0000_2468);
        cap_b   <= 1'b1;
        @(posedge clk_i);
        cap_b   <= 1'b0;
        count_i <= 16'h9ABC;
        wb(1'b0, OFS_CAPTURE_B, 32'h0);
        chk("cap_b_near", rd, 32'h0000_1357);
        $display("test capture done");
        chk("tff_init", {31'h0, tff}, 32'h0);
        wb(1'b1, OFS_CONTROL, 32'h0000_0001);
        pulse(1'b0);
        chk("tff_toggle", {31'h0, tff}, 32'h1);
        pulse(1'b1);
        chk("tff_b_no", {31'h0, tff}, 32'h1);
        wb(1'b1, OFS_CONTROL, 32'h0000_0000);
        pulse(1'b0);
        chk("tff_disabled", {31'h0, tff}, 32'h1);
        $display("test toggle done");
        chk("flag_a_idle", {31'h0, flag_a}, 32'h0);
        count_i <= 16'hABCD;
        @(posedge clk_i);
        count_i <= 16'h0001;
        @(posedge clk_i);
        chk("flag_a_set", {31'h0, flag_a}, 32'h1);
        chk("flag_b_idle", {31'h0, flag_b}, 32'h0);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0000_0001);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("status_clr", rd, 32'h0000_0000);
        // Match at the clearing edge must keep the flag
        count_i <= 16'hABCD;
        wb(1'b0, OFS_STATUS, 32'h0);
        chk("flag_a_set_wins", {31'h0, flag_a}, 32'h1);
        $display("test match done");
        count_i   <= 16'h0001;
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk("cmp_a_rst2", {16'h0, cmp_a}, 32'h0);
        chk("cmp_b_rst2", {16'h0, cmp_b}, 32'h0);
        chk("tff_rst2", {31'h0, tff}, 32'h0);
        chk("flag_a_rst2", {31'h0, flag_a}, 32'h0);
        wb(1'b0, OFS_COMPARE_A, 32'h0);
        chk("cmp_a_rd_rst2", rd, 32'h0);
        $display("test reset again done");
        test_done();
    end
endmodule
`default_nettype wire
